// >>> scd_clock_ctrl.sv
// Clock control top: AHB-Lite registers, prescaler control, trim and PLL.
// Assumes fuse and status pins are static or slow; they are synchronised.
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module scd_clock_ctrl
   import scd_pkg::*;
#(
   parameter int LOCK_CYCLES = PLL_LOCK_CYC
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic clock_out_fuse,
   input wire logic start_divide_fuse,
   input wire logic [7:0] factory_trim,
   input wire logic pll_is_sysclk,
   input wire logic core_reset_req,
   input wire logic gpio_out,
   input wire logic gpio_oe,
   output logic clock_out_pin,
   output logic clock_out_pin_oe,
   output scd_clk_en_s sys_clk_en,
   output scd_trim_s rc_trim,
   output logic pll_enable,
   output logic pll_rate,
   output logic rc_osc_enable
);

   // Pin synchronisers
   logic [11:0] pins_meta_reg;
   logic [11:0] pins_sync_reg;
   logic fuse_out_s;
   logic fuse_div_s;
   logic pll_sys_s;
   logic core_rst_s;
   logic [7:0] factory_s;

   // Start-up loading
   logic [1:0] init_cnt_reg;
   logic reload;

   // Bus slave
   scd_bus_e bus_st_reg;
   logic [7:0] addr_reg;
   logic [31:0] hrdata_reg;
   logic hreadyout_reg;
   logic accept;
   logic wr_en;
   logic wr_div;
   logic [7:0] wbyte;

   // Registers
   logic [7:0] trim_reg;
   logic pll_on_reg;
   logic pll_rate_reg;
   logic pll_lock_reg;
   logic [23:0] lock_cnt_reg;
   logic pll_en_eff;
   logic pll_enable_reg;
   logic rc_osc_enable_reg;
   logic unlock_reg;
   logic [2:0] unlock_cnt_reg;
   logic [3:0] div_sel_reg;

   // Divided clock
   logic div_tick;
   logic div_level;
   logic pin_reg;
   logic pin_oe_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pins_meta_reg <= 12'h000;
         pins_sync_reg <= 12'h000;
      end else begin
         pins_meta_reg <= {clock_out_fuse, start_divide_fuse, pll_is_sysclk, core_reset_req, factory_trim};
         pins_sync_reg <= pins_meta_reg;
      end
   end

   assign fuse_out_s = pins_sync_reg[11];
   assign fuse_div_s = pins_sync_reg[10];
   assign pll_sys_s = pins_sync_reg[9];
   assign core_rst_s = pins_sync_reg[8];
   assign factory_s = pins_sync_reg[7:0];

   // Loads fuse values once the synchronisers hold valid pin levels
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         init_cnt_reg <= 2'h0;
      end else if (init_cnt_reg != INIT_DONE) begin
         init_cnt_reg <= 2'(init_cnt_reg + 2'h1);
      end
   end

   assign reload = (init_cnt_reg == INIT_LOAD) || core_rst_s;

   // AHB-Lite slave: writes without wait, reads with one wait state
   assign accept = hsel && htrans[1] && hready;
   assign wr_en = bus_st_reg == BUS_WR;
   assign wr_div = wr_en && (addr_reg == OFS_DIV);
   assign wbyte = hwdata[7:0];

   function automatic logic [31:0] read_mux(input logic [7:0] a);
      logic [31:0] d;
      d = RDATA_RST;
      unique case (a)
         OFS_TRIM: d[7:0] = trim_reg;
         OFS_PLL: begin
            d[PLL_RATE_BIT] = pll_rate_reg;
            d[PLL_ON_BIT] = pll_en_eff;
            d[PLL_LOCK_BIT] = pll_lock_reg;
         end
         OFS_DIV: begin
            d[DIV_UNLOCK_BIT] = unlock_reg;
            d[3:0] = div_sel_reg;
         end
         default: d = RDATA_RST;
      endcase
      return d;
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_st_reg <= BUS_IDLE;
         addr_reg <= 8'h00;
         hreadyout_reg <= 1'b1;
         hrdata_reg <= RDATA_RST;
      end else begin
         unique case (bus_st_reg)
            BUS_IDLE, BUS_WR: begin
               if (accept) begin
                  addr_reg <= haddr[7:0];
                  bus_st_reg <= hwrite ? BUS_WR : BUS_RD;
                  hreadyout_reg <= hwrite;
               end else begin
                  bus_st_reg <= BUS_IDLE;
               end
            end
            BUS_RD: begin
               hrdata_reg <= read_mux(addr_reg);
               hreadyout_reg <= 1'b1;
               bus_st_reg <= BUS_IDLE;
            end
            default: begin
               bus_st_reg <= BUS_IDLE;
               hreadyout_reg <= 1'b1;
            end
         endcase
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp = 1'b0;

   // Oscillator trim, factory value on load
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trim_reg <= TRIM_RST;
      end else if (reload) begin
         trim_reg <= factory_s;
      end else if (wr_en && addr_reg == OFS_TRIM) begin
         trim_reg <= wbyte;
      end
   end

   assign rc_trim.range_hi = trim_reg[TRIM_RANGE_BIT];
   assign rc_trim.fine = trim_reg[6:0];

   // PLL control bits
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pll_on_reg <= 1'b0;
         pll_rate_reg <= 1'b0;
      end else if (reload) begin
         pll_on_reg <= 1'b0;
         pll_rate_reg <= 1'b0;
      end else if (wr_en && addr_reg == OFS_PLL) begin
         pll_on_reg <= wbyte[PLL_ON_BIT];
         pll_rate_reg <= wbyte[PLL_RATE_BIT];
      end
   end

   assign pll_en_eff = pll_on_reg || pll_sys_s;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pll_enable_reg <= 1'b0;
         rc_osc_enable_reg <= 1'b0;
      end else begin
         pll_enable_reg <= pll_en_eff;
         rc_osc_enable_reg <= pll_en_eff;
      end
   end

   assign pll_enable = pll_enable_reg;
   assign pll_rate = pll_rate_reg;
   assign rc_osc_enable = rc_osc_enable_reg;

   // Lock timer restarts whenever the PLL is off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_cnt_reg <= 24'h000000;
         pll_lock_reg <= 1'b0;
      end else if (!pll_enable_reg) begin
         lock_cnt_reg <= 24'h000000;
         pll_lock_reg <= 1'b0;
      end else if (lock_cnt_reg == 24'(LOCK_CYCLES - 1)) begin
         pll_lock_reg <= 1'b1;
      end else begin
         lock_cnt_reg <= 24'(lock_cnt_reg + 24'h000001);
      end
   end

   // Unlock bit with fixed window, never extended
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         unlock_reg <= 1'b0;
         unlock_cnt_reg <= 3'h0;
      end else if (reload) begin
         unlock_reg <= 1'b0;
         unlock_cnt_reg <= 3'h0;
      end else if (wr_div && wbyte == UNLOCK_WORD && !unlock_reg) begin
         unlock_reg <= 1'b1;
         unlock_cnt_reg <= 3'h0;
      end else if (unlock_reg && wr_div && !wbyte[DIV_UNLOCK_BIT]) begin
         unlock_reg <= 1'b0;
      end else if (unlock_reg && unlock_cnt_reg == UNLOCK_LAST) begin
         unlock_reg <= 1'b0;
      end else if (unlock_reg) begin
         unlock_cnt_reg <= 3'(unlock_cnt_reg + 3'h1);
      end
   end

   // Select accepted only inside the window, any value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_sel_reg <= DIV_SEL_PLAIN;
      end else if (reload) begin
         div_sel_reg <= fuse_div_s ? DIV_SEL_FUSED : DIV_SEL_PLAIN;
      end else if (wr_div && unlock_reg && !wbyte[DIV_UNLOCK_BIT]) begin
         div_sel_reg <= wbyte[3:0];
      end
   end

   scd_prescaler u_prescaler (
      .hclk(hclk),
      .hresetn(hresetn),
      .div_sel(div_sel_reg),
      .tick(div_tick),
      .clk_level(div_level)
   );

   // One enable for every synchronous domain
   assign sys_clk_en.io = div_tick;
   assign sys_clk_en.adc = div_tick;
   assign sys_clk_en.cpu = div_tick;
   assign sys_clk_en.flash = div_tick;

   // Pin override keeps running through core reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
      end else if (fuse_out_s) begin
         pin_reg <= div_level;
         pin_oe_reg <= 1'b1;
      end else begin
         pin_reg <= gpio_out;
         pin_oe_reg <= gpio_oe;
      end
   end

   assign clock_out_pin = pin_reg;
   assign clock_out_pin_oe = pin_oe_reg;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_clkout_pin: assert property (fuse_out_s |=> pin_oe_reg && pin_reg == $past(div_level))
      else $error("clock output pin not driven with divided clock");
   a_unlock_window: assert property ($rose(unlock_reg) |-> ##[1:4] !unlock_reg)
      else $error("unlock bit outlived its window");
   a_unlock_stays: assert property (($rose(unlock_reg) && !wr_div && !reload) ##1
      (!wr_div && !reload)[*2] |=> unlock_reg)
      else $error("unlock bit cleared early");
   a_unlock_guard: assert property ((wr_div && wbyte[6:0] != 7'h00 && !unlock_reg && !reload)
      |=> $stable(unlock_reg))
      else $error("unlock bit changed by a dirty write");
   a_div_sel_guard: assert property ((!unlock_reg && !reload) |=> $stable(div_sel_reg))
      else $error("select changed without unlock");
   a_reset_sel: assert property (reload |=> div_sel_reg == ($past(fuse_div_s) ? DIV_SEL_FUSED : DIV_SEL_PLAIN))
      else $error("select not loaded from fuse");
   a_trim_load: assert property (reload |=> trim_reg == $past(factory_s))
      else $error("trim not loaded with factory value");
   a_pll_reserved: assert property ((bus_st_reg == BUS_RD && addr_reg == OFS_PLL) |=> hrdata_reg[31:3] == 29'h0)
      else $error("reserved PLL bits read nonzero");
   a_pll_readback: assert property ((bus_st_reg == BUS_RD && addr_reg == OFS_PLL && pll_sys_s) |=> hrdata_reg[1])
      else $error("PLL enable reads zero while PLL clocks the system");
   a_lock_needs_on: assert property (!pll_enable_reg |=> !pll_lock_reg)
      else $error("lock flag without PLL enabled");
   a_lock_delay: assert property ($rose(pll_enable_reg) |-> !pll_lock_reg[*2])
      else $error("lock flag set too soon");
   a_read_wait: assert property ((accept && !hwrite) |=> !hreadyout_reg ##1 hreadyout_reg)
      else $error("read answer not after one wait state");

   c_div_change: cover property (unlock_reg ##1 wr_div ##1 !unlock_reg);
   c_pll_lock: cover property ($rose(pll_lock_reg));
   c_reserved_sel: cover property (div_sel_reg > DIV_SEL_MAX);
   c_unlock_expire: cover property (unlock_reg && unlock_cnt_reg == UNLOCK_LAST);

endmodule

// >>> scd_pkg.sv
// Constants, types and helpers for the system clock divider and PLL control.
// Assumes a single 125 MHz bus clock and an AHB-Lite master.
package scd_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_TRIM = 8'h00;
   localparam logic [7:0] OFS_PLL = 8'h04;
   localparam logic [7:0] OFS_DIV = 8'h08;

   // Field positions
   localparam int DIV_UNLOCK_BIT = 7;
   localparam int PLL_RATE_BIT = 2;
   localparam int PLL_ON_BIT = 1;
   localparam int PLL_LOCK_BIT = 0;
   localparam int TRIM_RANGE_BIT = 7;

   // Reset and special values
   localparam logic [3:0] DIV_SEL_PLAIN = 4'h0;
   localparam logic [3:0] DIV_SEL_FUSED = 4'h3;
   localparam logic [3:0] DIV_SEL_MAX = 4'h8;
   localparam logic [7:0] UNLOCK_WORD = 8'h80;
   localparam logic [7:0] TRIM_RST = 8'h00;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
   localparam logic [1:0] INIT_LOAD = 2'h2;
   localparam logic [1:0] INIT_DONE = 2'h3;

   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int UNLOCK_CYCLES = 4;
   localparam logic [2:0] UNLOCK_LAST = 3'(UNLOCK_CYCLES - 1);
   localparam int PLL_LOCK_MS = 100;
   localparam int PLL_LOCK_CYC = (PLL_LOCK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_RD = 3'b010,
      BUS_WR = 3'b100
   } scd_bus_e;

   typedef struct packed {
      logic io;
      logic adc;
      logic cpu;
      logic flash;
   } scd_clk_en_s;

   typedef struct packed {
      logic range_hi;
      logic [6:0] fine;
   } scd_trim_s;

   // Last count of one divided period, for selects 0 to 8
   function automatic logic [7:0] scd_div_last(input logic [3:0] sel);
      logic [8:0] span;
      span = 9'h001 << sel;
      return 8'(span - 9'h001);
   endfunction

   function automatic logic scd_sel_legal(input logic [3:0] sel);
      return sel <= DIV_SEL_MAX;
   endfunction

endpackage

// >>> scd_prescaler.sv
// Divide counter running on the undivided clock, with glitch-free switching.
// Assumes the select comes from a register on the same clock.
`timescale 1ns/1ps
module scd_prescaler
   import scd_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [3:0] div_sel,
   output logic tick,
   output logic clk_level
);

   logic [7:0] cnt_reg;
   logic [3:0] cur_reg;
   logic tick_reg;
   logic level_reg;
   logic wrap;

   assign wrap = cnt_reg == scd_div_last(cur_reg);
   assign tick = tick_reg;
   assign clk_level = level_reg;

   // Count on every undivided edge, state not readable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= 8'h00;
      end else if (wrap) begin
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= 8'(cnt_reg + 8'h01);
      end
   end

   // New factor only at the end of a whole old period
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cur_reg <= DIV_SEL_PLAIN;
      end else if (wrap && scd_sel_legal(div_sel)) begin
         cur_reg <= div_sel;
      end
   end

   // Enable pulse and clock level, high in first half of period
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_reg <= 1'b0;
         level_reg <= 1'b0;
      end else begin
         tick_reg <= wrap;
         level_reg <= (cur_reg == DIV_SEL_PLAIN) || !cnt_reg[3'(cur_reg - 4'h1)];
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_switch_on_wrap: assert property ($changed(cur_reg) |-> $past(wrap))
      else $error("divide factor changed inside a period");
   a_no_fast_tick: assert property ((tick_reg && cur_reg != DIV_SEL_PLAIN) |=> !tick_reg)
      else $error("divided clock faster than selected");
   a_reserved_held: assert property (!scd_sel_legal(div_sel) |=> $stable(cur_reg))
      else $error("reserved select reached the counter");

endmodule

// >>> testbench.sv
// Self-checking bench for the clock control block: bus, divider, trim, PLL, pin.
// Assumes the block's hreadyout is fed back as its hready; LOCK_CYCLES shortened.
`timescale 1ns/1ps
module testbench;
   import scd_pkg::*;
   localparam int LOCKN = 20;
   logic hclk = 0;
   logic hresetn = 0;
   logic hsel = 0;
   logic hwrite = 0;
   logic [31:0] haddr = 0;
   logic [31:0] hwdata = 0;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hrdata;
   logic hrdy, hresp, cop, cop_oe, pll_en, pll_rt, rc_en;
   logic cfuse = 1;
   logic dfuse = 1;
   logic pll_sys = 0;
   logic crst = 0;
   logic gout = 0;
   logic goe = 0;
   logic [7:0] ftrim = 8'hA5;
   scd_clk_en_s en;
   scd_trim_s trim;
   int error_cnt = 0;
   int checks_done = 0;
   int per, sel_m, act_m;
   logic [31:0] rd, v;

   scd_clock_ctrl #(.LOCK_CYCLES(LOCKN)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
      .clock_out_fuse(cfuse), .start_divide_fuse(dfuse), .factory_trim(ftrim),
      .pll_is_sysclk(pll_sys), .core_reset_req(crst), .gpio_out(gout), .gpio_oe(goe),
      .clock_out_pin(cop), .clock_out_pin_oe(cop_oe), .sys_clk_en(en), .rc_trim(trim),
      .pll_enable(pll_en), .pll_rate(pll_rt), .rc_osc_enable(rc_en));

   always #4 hclk = ~hclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      hsel <= 1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= 1;
      do @(posedge hclk); while (hrdy !== 1'b1);
      hsel <= 0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hrdy !== 1'b1);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      hsel <= 1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= 0;
      do @(posedge hclk); while (hrdy !== 1'b1);
      hsel <= 0;
      htrans <= 2'b00;
      do @(posedge hclk); while (hrdy !== 1'b1);
      chk(hrdata, exp);
   endtask

   // Cycles between two enable pulses, or two rising edges of the pin
   task automatic measure(input bit pin, output int p);
      logic prev;
      int st;
      prev = cop;
      st = -1;
      p = 0;
      for (int i = 0; i < 700 && p == 0; i++) begin
         @(posedge hclk);
         if (pin ? (cop === 1'b1 && prev === 1'b0) : (en.io === 1'b1)) begin
            if (st < 0) st = i;
            else p = i - st;
         end
         prev = cop;
      end
      chk(32'(en), {28'h0, {4{en.io}}});
   endtask

   task automatic div_set(input int s);
      bus_wr(OFS_DIV, 32'h80);
      bus_wr(OFS_DIV, 32'(s));
      sel_m = s;
      if (s <= 8) act_m = 1 << s;
   endtask

   task automatic div_go(input int s);
      int old, last, b4, b5;
      old = act_m;
      last = 0;
      b4 = 0;
      b5 = 0;
      div_set(s);
      for (int i = 1; i <= old + 4 * act_m; i++) begin
         @(posedge hclk);
         if (en.io === 1'b1) begin
            if (last > 0 && i - last < (old < act_m ? old : act_m)) b4++;
            if (last > old + 2 * act_m && i - last != act_m) b5++;
            last = i;
         end
      end
      chk(b4, 0);
      chk(b5, 0);
      rd_chk(OFS_DIV, sel_m);
      measure(0, per);
      chk(per, act_m);
      if (s > 0) begin
         measure(1, per);
         chk(per, act_m);
      end else begin
         chk(cop, 1'b1);
      end
   endtask

   initial begin
      void'($urandom(32'h910941d4));
      repeat (4) @(posedge hclk);
      hresetn <= 1;
      idle(4);
      sel_m = 3;
      act_m = 8;
      chk(hresp, 1'b0);
      rd_chk(OFS_TRIM, ftrim);
      rd_chk(OFS_DIV, 32'h3);
      rd_chk(OFS_PLL, 32'h0);
      chk(cop_oe, 1'b1);
      measure(1, per);
      chk(per, 8);
      for (int i = 0; i < 9; i++) div_go((i * 5) % 9);
      v = 32'($urandom_range(15, 9));
      div_set(v);
      rd_chk(OFS_DIV, v);
      measure(0, per);
      chk(per, act_m);
      bus_wr(OFS_DIV, 32'h5);
      rd_chk(OFS_DIV, sel_m);
      bus_wr(OFS_DIV, 32'h81);
      bus_wr(OFS_DIV, 32'h5);
      rd_chk(OFS_DIV, sel_m);
      bus_wr(OFS_DIV, 32'h80);
      idle(4);
      bus_wr(OFS_DIV, 32'h5);
      rd_chk(OFS_DIV, sel_m);
      bus_wr(OFS_DIV, 32'h80);
      bus_wr(OFS_DIV, 32'h80);
      idle(1);
      bus_wr(OFS_DIV, 32'h5);
      rd_chk(OFS_DIV, sel_m);
      div_go(2);
      bus_wr(8'h0C, $urandom);
      rd_chk(8'h0C, 32'h0);
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 32'h7F : (i == 1) ? 32'h80 : $urandom;
         bus_wr(OFS_TRIM, v);
         rd_chk(OFS_TRIM, {24'h0, v[7:0]});
         chk(32'(trim), {24'h0, v[7:0]});
         chk(trim.fine, v[6:0]);
      end
      bus_wr(OFS_PLL, 32'hFFFF_FFFB);
      rd_chk(OFS_PLL, 32'h2);
      chk({pll_en, rc_en, pll_rt}, 3'b110);
      idle(LOCKN + 2);
      rd_chk(OFS_PLL, 32'h3);
      bus_wr(OFS_PLL, 32'h4);
      idle(2);
      rd_chk(OFS_PLL, 32'h4);
      chk({pll_en, pll_rt}, 2'b01);
      pll_sys <= 1;
      idle(4);
      rd_chk(OFS_PLL, 32'h6);
      chk(pll_en, 1'b1);
      pll_sys <= 0;
      for (int f = 1; f >= 0; f--) begin
         dfuse <= f[0];
         crst <= 1;
         idle(30);
         chk(cop_oe, 1'b1);
         if (f == 1) begin
            measure(1, per);
            chk(per, 8);
         end
         crst <= 0;
         idle(4);
         rd_chk(OFS_DIV, f ? 32'h3 : 32'h0);
         rd_chk(OFS_PLL, 32'h0);
         rd_chk(OFS_TRIM, ftrim);
      end
      cfuse <= 0;
      for (int i = 0; i < 4; i++) begin
         gout <= $urandom;
         goe <= $urandom;
         idle(5);
         chk({cop, cop_oe}, {gout, goe});
      end
      give_verdict();
   end

   initial begin
      #400000;
      error_cnt++;
      give_verdict();
   end
endmodule
